//--- src/vcc_pkg.sv
// constants, register map and carrier types of the voltage comparator control block
// assumes an apb master on pclk and an analog comparator core driving one async result line
// How it works
// R01 - enable bit 7 powers the comparator
// R02 - disabled: pin outputs low, supply off
// R03 - bit 6 reads live comparator result
// R04 - falling edge sets flag bit 4
// R05 - rising edge sets flag bit 5
// R06 - edge flags sticky, only software clears
// R07 - rise enable gates rise interrupt
// R08 - fall enable gates fall interrupt
// R09 - positive hysteresis code to analog core
// R10 - negative hysteresis, same encoding
// R11 - response mode field picks speed/power
// R12 - unused mode bits read zero
// R13 - latched and raw outputs for pins
// R14 - raw output needs no clock
// R15 - first instance offers reset source
// R16 - software clears flags after reconfiguring
// R17 - interrupt from flag and enable pairs
// R18 - edges found on synchronised samples
package vcc_pkg;

  localparam int unsigned ADDR_W = 12;
  // printed offsets are indices; byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'h9b;
  localparam logic [7:0] IDX_MODE = 8'h9d;
  localparam logic [7:0] IDX_STAT = 8'ha0;
  localparam logic [7:0] IDX_MASK = 8'ha1;

  localparam int unsigned CTL_EN = 7;
  localparam int unsigned CTL_RES = 6;
  localparam int unsigned CTL_RISE = 5;
  localparam int unsigned CTL_FALL = 4;
  localparam int unsigned CTL_HYP = 2;
  localparam int unsigned CTL_HYN = 0;
  localparam int unsigned MD_RIE = 5;
  localparam int unsigned MD_FIE = 4;
  localparam int unsigned MD_MODE = 0;
  localparam int unsigned EV_RISE = 0;
  localparam int unsigned EV_FALL = 1;

  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [1:0] MASK_RST = 2'h0;

  // hysteresis: off, 5 mV, 10 mV, 20 mV
  localparam logic [1:0] HYST_OFF = 2'h0;
  localparam logic [1:0] HYST_20MV = 2'h3;
  // response: fastest/highest power up to slowest/lowest power
  localparam logic [1:0] RESP_FAST = 2'h0;
  localparam logic [1:0] RESP_SLOW = 2'h3;

  typedef enum logic [1:0] {
    VCC_IDLE = 2'b01,
    VCC_ACC = 2'b10
  } vcc_phase_t;

  typedef enum logic [2:0] {
    VCC_RS_NONE,
    VCC_RS_CTRL,
    VCC_RS_MODE,
    VCC_RS_STAT,
    VCC_RS_MASK
  } vcc_reg_t;

  typedef struct packed {
    logic en;
    logic rflag;
    logic fflag;
    logic [1:0] hyp;
    logic [1:0] hyn;
  } vcc_ctl_t;

  typedef struct packed {
    logic rie;
    logic fie;
    logic [1:0] mode;
  } vcc_md_t;

  typedef struct packed {
    logic power_en;
    logic [1:0] hyst_pos;
    logic [1:0] hyst_neg;
    logic [1:0] resp_mode;
  } vcc_ana_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } vcc_sync_t;

  typedef struct packed {
    logic prev;
  } vcc_edge_t;

  typedef struct packed {
    vcc_phase_t ph;
    vcc_ctl_t ctl;
    vcc_md_t md;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic lat;
    logic rst_src;
  } vcc_state_t;

endpackage : vcc_pkg

//--- src/vcc_sync2.sv
// two-flop synchroniser for the asynchronous comparator result
// assumes pclk domain; only the second flop is visible
`timescale 1ns/1ns
module vcc_sync2 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic async_in,
  output logic sync_out
);
  vcc_pkg::vcc_sync_t s_r;
  vcc_pkg::vcc_sync_t s_nxt;

  always_comb begin
    s_nxt.s1 = async_in;
    s_nxt.s2 = s_r.s1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign sync_out = s_r.s2;
endmodule : vcc_sync2

//--- src/vcc_edge_det.sv
// rise and fall pulses from a synchronised level
// assumes the input is already in the pclk domain
`timescale 1ns/1ns
module vcc_edge_det (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic level,
  output logic rise_p,
  output logic fall_p
);
  vcc_pkg::vcc_edge_t e_r;
  vcc_pkg::vcc_edge_t e_nxt;

  always_comb begin
    e_nxt.prev = level;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      e_r <= '0;
    end else begin
      e_r <= e_nxt;
    end
  end

  // each sample against the previous one [R18]
  assign rise_p = level & ~e_r.prev;
  assign fall_p = ~level & e_r.prev;
endmodule : vcc_edge_det

//--- src/vcc_ctrl.sv
// voltage comparator control: apb registers, edge flags, interrupt, pin outputs
// assumes apb3 master on pclk and an analog core whose result line is asynchronous
`timescale 1ns/1ns
module vcc_ctrl #(
  parameter bit FIRST_INST = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [vcc_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmp_core_out,
  output vcc_pkg::vcc_ana_t ana_cfg,
  output logic latched_cmp_output,
  output logic raw_cmp_output,
  output logic cmp_reset_src,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode, used for both read and write

  function automatic vcc_pkg::vcc_reg_t reg_sel(
    input logic [vcc_pkg::ADDR_W-1:0] a
  );
    vcc_pkg::vcc_reg_t r;
    r = vcc_pkg::VCC_RS_NONE;
    if (a[1:0] == 2'h0) begin
      case (a[9:2])
        vcc_pkg::IDX_CTRL: r = vcc_pkg::VCC_RS_CTRL;
        vcc_pkg::IDX_MODE: r = vcc_pkg::VCC_RS_MODE;
        vcc_pkg::IDX_STAT: r = vcc_pkg::VCC_RS_STAT;
        vcc_pkg::IDX_MASK: r = vcc_pkg::VCC_RS_MASK;
        default: r = vcc_pkg::VCC_RS_NONE;
      endcase
    end
    if (a[vcc_pkg::ADDR_W-1:10] != '0) begin
      r = vcc_pkg::VCC_RS_NONE;
    end
    return r;
  endfunction : reg_sel

  ////////////////////////////////////////////////////////////////////////////
  // comparator result into the clock domain

  vcc_pkg::vcc_state_t st_r;
  vcc_pkg::vcc_state_t st_nxt;
  logic cmp_sync;
  logic cmp_live;
  logic rise_p;
  logic fall_p;

  vcc_sync2 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(cmp_core_out),
    .sync_out(cmp_sync)
  );

  // a powered-down core gives no result; enabling it may flag a false edge
  assign cmp_live = cmp_sync & st_r.ctl.en;

  vcc_edge_det u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .level(cmp_live),
    .rise_p(rise_p),
    .fall_p(fall_p)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  vcc_pkg::vcc_reg_t sel;
  logic done;
  logic [7:0] ctl_rd;
  logic [7:0] md_rd;
  logic [1:0] req;

  always_comb begin
    sel = reg_sel(paddr);
    done = psel & penable & st_r.pready;
    ctl_rd = {st_r.ctl.en, cmp_live, st_r.ctl.rflag, st_r.ctl.fflag, // [R03]
              st_r.ctl.hyp, st_r.ctl.hyn};
    // unused mode bits never stored, so they read zero [R12]
    md_rd = {2'h0, st_r.md.rie, st_r.md.fie, 2'h0, st_r.md.mode};
    req[vcc_pkg::EV_RISE] = st_r.ctl.rflag & st_r.md.rie; // [R07] [R17]
    req[vcc_pkg::EV_FALL] = st_r.ctl.fflag & st_r.md.fie; // [R08] [R17]
  end

  always_comb begin
    st_nxt = st_r;

    // bus phases: zero wait, answer in the first access cycle
    case (st_r.ph)
      vcc_pkg::VCC_IDLE: begin
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        if (psel && !penable) begin
          st_nxt.ph = vcc_pkg::VCC_ACC;
          st_nxt.pready = 1'b1;
          st_nxt.pslverr = (sel == vcc_pkg::VCC_RS_NONE);
          st_nxt.prdata = '0;
          if (!pwrite) begin
            case (sel)
              vcc_pkg::VCC_RS_CTRL: st_nxt.prdata[7:0] = ctl_rd;
              vcc_pkg::VCC_RS_MODE: st_nxt.prdata[7:0] = md_rd;
              vcc_pkg::VCC_RS_STAT: st_nxt.prdata[1:0] = st_r.stat;
              vcc_pkg::VCC_RS_MASK: st_nxt.prdata[1:0] = st_r.mask;
              default: st_nxt.prdata = '0;
            endcase
          end
        end
      end
      vcc_pkg::VCC_ACC: begin
        st_nxt.ph = vcc_pkg::VCC_IDLE;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
      end
      default: begin
        st_nxt.ph = vcc_pkg::VCC_IDLE;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
      end
    endcase

    // register writes land at the completing edge
    if (done && pwrite) begin
      case (sel)
        vcc_pkg::VCC_RS_CTRL: begin
          st_nxt.ctl.en = pwdata[vcc_pkg::CTL_EN]; // [R01]
          st_nxt.ctl.rflag = pwdata[vcc_pkg::CTL_RISE]; // [R06]
          st_nxt.ctl.fflag = pwdata[vcc_pkg::CTL_FALL]; // [R06]
          st_nxt.ctl.hyp = pwdata[vcc_pkg::CTL_HYP +: 2]; // [R09]
          st_nxt.ctl.hyn = pwdata[vcc_pkg::CTL_HYN +: 2]; // [R10]
        end
        vcc_pkg::VCC_RS_MODE: begin
          st_nxt.md.rie = pwdata[vcc_pkg::MD_RIE];
          st_nxt.md.fie = pwdata[vcc_pkg::MD_FIE];
          st_nxt.md.mode = pwdata[vcc_pkg::MD_MODE +: 2]; // [R11]
        end
        vcc_pkg::VCC_RS_MASK: begin
          st_nxt.mask = pwdata[1:0];
        end
        default: begin
          st_nxt.mask = st_r.mask;
        end
      endcase
    end

    // read clears only the bits that were actually returned
    if (done && !pwrite && sel == vcc_pkg::VCC_RS_STAT) begin
      st_nxt.stat = st_r.stat & ~st_r.prdata[1:0];
    end

    // hardware only ever sets, and a set beats a same-cycle clear [R06]
    if (rise_p) begin
      st_nxt.ctl.rflag = 1'b1; // [R05]
      st_nxt.stat[vcc_pkg::EV_RISE] = 1'b1;
    end
    if (fall_p) begin
      st_nxt.ctl.fflag = 1'b1; // [R04]
      st_nxt.stat[vcc_pkg::EV_FALL] = 1'b1;
    end

    st_nxt.irq = (|req) | (|(st_r.stat & st_r.mask)); // [R17]

    // disabled core forces pin copies low [R02]
    st_nxt.lat = cmp_live; // [R13]
    st_nxt.rst_src = FIRST_INST & cmp_live; // [R15]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ph <= vcc_pkg::VCC_IDLE;
      st_r.ctl <= vcc_pkg::vcc_ctl_t'({vcc_pkg::CTRL_RST[7], vcc_pkg::CTRL_RST[5:0]});
      st_r.md <= vcc_pkg::vcc_md_t'({vcc_pkg::MODE_RST[5:4], vcc_pkg::MODE_RST[1:0]});
      st_r.stat <= 2'h0;
      st_r.mask <= vcc_pkg::MASK_RST;
      st_r.prdata <= 32'h0000_0000;
      st_r.pready <= 1'b0;
      st_r.pslverr <= 1'b0;
      st_r.irq <= 1'b0;
      st_r.lat <= 1'b0;
      st_r.rst_src <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign irq = st_r.irq;
  assign latched_cmp_output = st_r.lat;
  assign cmp_reset_src = st_r.rst_src;
  assign ana_cfg.power_en = st_r.ctl.en; // [R01] [R02]
  assign ana_cfg.hyst_pos = st_r.ctl.hyp; // [R09]
  assign ana_cfg.hyst_neg = st_r.ctl.hyn; // [R10]
  assign ana_cfg.resp_mode = st_r.md.mode; // [R11]

  // deliberately unclocked so it keeps working with pclk stopped [R13] [R14]
  assign raw_cmp_output = cmp_core_out & st_r.ctl.en;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic wr_ctl;
  logic wr_md;
  logic rd_ctl;
  logic rd_md;
  assign wr_ctl = done && pwrite && sel == vcc_pkg::VCC_RS_CTRL;
  assign wr_md = done && pwrite && sel == vcc_pkg::VCC_RS_MODE;
  assign rd_ctl = done && !pwrite && sel == vcc_pkg::VCC_RS_CTRL;
  assign rd_md = done && !pwrite && sel == vcc_pkg::VCC_RS_MODE;

  a_enable_write: assert property ( // [R01]
    wr_ctl |=> ana_cfg.power_en == $past(pwdata[vcc_pkg::CTL_EN]))
    else $error("enable bit not applied to core power");

  a_disabled_low: assert property ( // [R02]
    !ana_cfg.power_en |=> !latched_cmp_output && !cmp_reset_src)
    else $error("pin copy not low while disabled");

  a_result_read: assert property ( // [R03]
    (psel && !penable && !pwrite && sel == vcc_pkg::VCC_RS_CTRL)
      |=> prdata[vcc_pkg::CTL_RES] == $past(cmp_live))
    else $error("result bit does not show comparator state");

  a_fall_flag: assert property ( // [R04]
    fall_p |=> st_r.ctl.fflag)
    else $error("falling edge did not set flag");

  a_rise_flag: assert property ( // [R05]
    rise_p |=> st_r.ctl.rflag)
    else $error("rising edge did not set flag");

  a_flag_sticky: assert property ( // [R06]
    st_r.ctl.rflag && !wr_ctl |=> st_r.ctl.rflag)
    else $error("rise flag dropped without a write");

  a_irq_rise: assert property ( // [R07]
    st_r.ctl.rflag && st_r.md.rie |=> irq)
    else $error("enabled rise flag gave no interrupt");

  a_irq_quiet: assert property ( // [R08]
    !(|req) && !(|(st_r.stat & st_r.mask)) |=> !irq)
    else $error("interrupt without an enabled source");

  a_mode_write: assert property ( // [R11]
    wr_md ##1 !wr_md [*2] |-> ana_cfg.resp_mode == $past(pwdata[1:0], 2))
    else $error("response mode not forwarded");

  a_unused_zero: assert property ( // [R12]
    rd_md |-> prdata[7:6] == 2'h0 && prdata[3:2] == 2'h0)
    else $error("unused mode bits not zero");

  a_edge_source: assert property ( // [R18]
    rise_p |-> cmp_live && !$past(cmp_live))
    else $error("rise pulse without a synchronised edge");

  a_apb_answer: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("bus answer not in first access cycle");

  // the fall flag must be as sticky as the rise flag
  a_fall_sticky: assert property ( // [R06]
    st_r.ctl.fflag && !wr_ctl |=> st_r.ctl.fflag)
    else $error("fall flag dropped without a write");

  a_irq_fall: assert property ( // [R08]
    st_r.ctl.fflag && st_r.md.fie |=> irq)
    else $error("enabled fall flag gave no interrupt");

  a_hyst_pos: assert property ( // [R09]
    wr_ctl |=> ana_cfg.hyst_pos == $past(pwdata[vcc_pkg::CTL_HYP +: 2]))
    else $error("positive hysteresis not forwarded");

  a_hyst_neg: assert property ( // [R10]
    wr_ctl |=> ana_cfg.hyst_neg == $past(pwdata[vcc_pkg::CTL_HYN +: 2]))
    else $error("negative hysteresis not forwarded");

  a_md_enables: assert property ( // [R07] [R08]
    wr_md |=> st_r.md.rie == $past(pwdata[vcc_pkg::MD_RIE]) && st_r.md.fie == $past(pwdata[vcc_pkg::MD_FIE]))
    else $error("interrupt enables not stored");

  a_latched_follow: assert property ( // [R13]
    1'b1 |=> latched_cmp_output == $past(cmp_live))
    else $error("latched copy does not follow result");

  a_raw_gated: assert property ( // [R02]
    !ana_cfg.power_en |-> !raw_cmp_output)
    else $error("raw copy not low while disabled");

  a_reset_src: assert property ( // [R15]
    cmp_reset_src == (FIRST_INST && latched_cmp_output))
    else $error("reset source wrong for this instance");

  a_fall_source: assert property ( // [R18]
    fall_p |-> !cmp_live && $past(cmp_live))
    else $error("fall pulse without a synchronised edge");

  a_stat_set: assert property ( // [R17]
    rise_p |=> st_r.stat[vcc_pkg::EV_RISE])
    else $error("rise event not recorded in status");

  // status only drops through a read of the status register
  a_stat_hold: assert property ( // [R17]
    st_r.stat[vcc_pkg::EV_RISE] && !(done && !pwrite && sel == vcc_pkg::VCC_RS_STAT)
      |=> st_r.stat[vcc_pkg::EV_RISE])
    else $error("rise status lost without a read");

  a_err_unmapped: assert property (
    psel && !penable && sel == vcc_pkg::VCC_RS_NONE |=> pslverr)
    else $error("unmapped access gave no error");

  a_ready_once: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_upper_zero: assert property (
    pready |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");

  a_power_hold: assert property ( // [R01]
    !wr_ctl |=> $stable(ana_cfg.power_en))
    else $error("core power changed without a write");

  a_resp_hold: assert property ( // [R11]
    !wr_md |=> $stable(ana_cfg.resp_mode))
    else $error("response mode changed without a write");

endmodule : vcc_ctrl

//--- bench/vcc_cmp_model.sv
// behavioural analog comparator core seen by the control block
// assumes the bench sets the wanted result on lvl; it needs no clock
`timescale 1ns/1ns
module vcc_cmp_model (
  input wire logic lvl,
  input vcc_pkg::vcc_ana_t ana_cfg,
  output logic cmp_core_out
);
  logic lvl_d;
  initial lvl_d = 1'b0;
  // slower response modes settle later
  always @(lvl) lvl_d <= #(1 + 2 * ana_cfg.resp_mode) lvl;
  // unpowered core has no valid result: show the inverse
  assign cmp_core_out = ana_cfg.power_en ? lvl_d : ~lvl;
endmodule : vcc_cmp_model

//--- bench/tb.sv
// self-checking bench of the voltage comparator control block
// assumes vcc_ctrl with default parameters and the behavioural core model
`timescale 1ns/1ns
module tb;
  logic pclk, presetn, psel, penable, pwrite, lvl, clk_run;
  logic [vcc_pkg::ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd, d;
  logic pready, pslverr, err, cmp_core_out, latched, raw, rst_src, irq;
  vcc_pkg::vcc_ana_t ana_cfg;
  int n_fail, compares;
  localparam logic [11:0] A_CTRL = {2'h0, vcc_pkg::IDX_CTRL, 2'h0};
  localparam logic [11:0] A_MODE = {2'h0, vcc_pkg::IDX_MODE, 2'h0};
  localparam logic [11:0] A_STAT = {2'h0, vcc_pkg::IDX_STAT, 2'h0};
  localparam logic [11:0] A_MASK = {2'h0, vcc_pkg::IDX_MASK, 2'h0};

  vcc_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_core_out(cmp_core_out), .ana_cfg(ana_cfg), .latched_cmp_output(latched),
    .raw_cmp_output(raw), .cmp_reset_src(rst_src), .irq(irq)
  );
  vcc_cmp_model core (.lvl(lvl), .ana_cfg(ana_cfg), .cmp_core_out(cmp_core_out));

  // second instance on the same bus must never offer a reset source
  logic rst_src_b;
  vcc_ctrl #(.FIRST_INST(1'b0)) dut_b (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .cmp_core_out(cmp_core_out), .ana_cfg(), .latched_cmp_output(),
    .raw_cmp_output(), .cmp_reset_src(rst_src_b), .irq()
  );

  // clk_run lets the clock stop, as in the lowest-power state
  initial begin
    pclk = 1'b0;
    forever #2 if (clk_run) pclk = ~pclk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      final_report();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the write land before anyone looks at outputs
    #1;
  endtask : apb

  task automatic rdx(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, rd, exp);
  endtask : rdx

  task automatic wait_lat(input logic v);
    int k;
    k = 0;
    while (latched !== v && k < 30) begin
      @(posedge pclk);
      k++;
    end
    chk("latched", latched, v);
    // flag lands with latched, irq one cycle later
    repeat (2) @(posedge pclk);
    #1;
  endtask : wait_lat

  task automatic set_lvl(input logic v);
    @(posedge pclk);
    lvl <= v;
  endtask : set_lvl

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk_run = 1'b1;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    lvl = 1'b0;
    n_fail = 0;
    compares = 0;
    void'($urandom(32'h0b2a));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdx(A_CTRL, 32'h0, "ctrl reset");
    rdx(A_MODE, 32'h2, "mode reset");
    chk("resp reset", ana_cfg.resp_mode, 2'h2);
    chk("irq reset", irq, 1'b0);
    for (int i = 0; i < 4; i++) begin
      d = $urandom;
      d[1:0] = i[1:0];
      apb(1'b1, A_MODE, d);
      rdx(A_MODE, d & 32'h33, "mode rw");
      chk("resp mode", ana_cfg.resp_mode, i[1:0]);
    end
    apb(1'b1, A_MODE, 32'h0);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, A_CTRL, {24'h0, 4'h8, i[3:0]});
      chk("hyst pos", ana_cfg.hyst_pos, i[3:2]);
      chk("hyst neg", ana_cfg.hyst_neg, i[1:0]);
      chk("power on", ana_cfg.power_en, 1'b1);
    end
    // disabled: core output is junk, pins must read low
    apb(1'b1, A_CTRL, 32'h4f);
    rdx(A_CTRL, 32'h0f, "ctrl off");
    chk("power off", ana_cfg.power_en, 1'b0);
    repeat (4) @(posedge pclk);
    #1;
    chk("raw off", raw, 1'b0);
    chk("latched off", latched, 1'b0);
    apb(1'b1, A_CTRL, 32'h80);
    repeat (6) @(posedge pclk);
    apb(1'b1, A_CTRL, 32'h80);
    apb(1'b0, A_STAT, 32'h0);
    rdx(A_CTRL, 32'h80, "ctrl on");
    chk("mapped err", err, 1'b0);
    set_lvl(1'b1);
    wait_lat(1'b1);
    chk("raw on", raw, 1'b1);
    chk("reset src", rst_src, 1'b1);
    chk("reset src second", rst_src_b, 1'b0);
    rdx(A_CTRL, 32'he0, "rise flag");
    chk("irq no rie", irq, 1'b0);
    apb(1'b1, A_MODE, 32'h20);
    @(posedge pclk);
    #1;
    chk("irq rie", irq, 1'b1);
    apb(1'b1, A_MODE, 32'h10);
    @(posedge pclk);
    #1;
    chk("irq fie only", irq, 1'b0);
    set_lvl(1'b0);
    wait_lat(1'b0);
    chk("irq fall", irq, 1'b1);
    rdx(A_CTRL, 32'hb0, "both flags");
    apb(1'b1, A_CTRL, 32'h80);
    rdx(A_CTRL, 32'h80, "flags cleared");
    chk("irq cleared", irq, 1'b0);
    rdx(A_STAT, 32'h3, "status");
    rdx(A_STAT, 32'h0, "status read clear");
    apb(1'b1, A_MASK, 32'h1);
    apb(1'b1, A_MODE, 32'h0);
    set_lvl(1'b1);
    wait_lat(1'b1);
    chk("irq masked in", irq, 1'b1);
    rdx(A_STAT, 32'h1, "status rise");
    @(posedge pclk);
    #1;
    chk("irq status gone", irq, 1'b0);
    apb(1'b1, A_CTRL, 32'h80);
    apb(1'b0, A_CTRL | 12'h001, 32'h0);
    chk("misaligned err", err, 1'b1);
    chk("misaligned data", rd, 32'h0);
    apb(1'b1, A_CTRL | 12'hc00, 32'hff);
    chk("alias err", err, 1'b1);
    rdx(A_CTRL, 32'hc0, "alias ignored");
    // raw path must follow the core with no clock at all
    @(negedge pclk);
    clk_run = 1'b0;
    lvl = 1'b0;
    #20;
    chk("raw stopped low", raw, 1'b0);
    lvl = 1'b1;
    #20;
    chk("raw stopped high", raw, 1'b1);
    clk_run = 1'b1;
    final_report();
  end
endmodule : tb
